/* File: hw/ssq_defs.svh */
// constants of the step/direction microstep sequencer
`ifndef SSQ_DEFS_SVH
`define SSQ_DEFS_SVH

// register byte addresses
`define SSQ_ADDR_CTRL 4'h0
`define SSQ_ADDR_STATUS 4'h4
`define SSQ_ADDR_INT_STATUS 4'h8
`define SSQ_ADDR_INT_MASK 4'hc

// control fields
`define SSQ_CTRL_RES_LSB 0
`define SSQ_CTRL_RES_MSB 3
`define SSQ_CTRL_IDX_TGL_BIT 4
`define SSQ_CTRL_RES_RST 4'h4
`define SSQ_CTRL_IDX_TGL_RST 1'b0

// status fields
`define SSQ_STAT_POS_LSB 0
`define SSQ_STAT_POS_MSB 9
`define SSQ_STAT_STST_BIT 16
`define SSQ_STAT_STBY_BIT 17

// interrupt bits
`define SSQ_INT_STST_BIT 0
`define SSQ_INT_INDEX_BIT 1
`define SSQ_INT_MASK_RST 2'h0

// resolution exponent of fullstepping (step width 256)
`define SSQ_RES_FULL 4'h8

// longest microstep spacing / standstill period, in clock cycles
`define SSQ_STST_CYCLES 1048576

// position after reset
`define SSQ_POS_RST 10'h000

// bus responses
`define SSQ_RESP_OKAY 2'h0
`define SSQ_RESP_SLVERR 2'h2

`endif

/* File: hw/ssq_pkg.sv */
// types shared by the step/direction microstep sequencer
package ssq_pkg;
   typedef logic [9:0] ssq_pos_t;
   typedef logic signed [8:0] ssq_cur_t;
   typedef logic [1:0] ssq_resp_t;
   typedef logic [3:0] ssq_res_t;
endpackage

/* File: hw/ssq_sine_lut.sv */
// sine/cosine lookup over 1024 positions, quarter table with interpolation
`timescale 1ns/1ps
`default_nettype none

module ssq_sine_lut (
   input wire ssq_pkg::ssq_pos_t pos,
   output ssq_pkg::ssq_cur_t sin_val,
   output ssq_pkg::ssq_cur_t cos_val
);

   // -------------------------------------------------------------
   // quarter wave, 33 knots, 255 full scale
   // -------------------------------------------------------------
   function automatic logic [7:0] knot(input logic [5:0] i);
      case (i)
         6'd0: knot = 8'h00;
         6'd1: knot = 8'h0d;
         6'd2: knot = 8'h19;
         6'd3: knot = 8'h25;
         6'd4: knot = 8'h32;
         6'd5: knot = 8'h3e;
         6'd6: knot = 8'h4a;
         6'd7: knot = 8'h56;
         6'd8: knot = 8'h62;
         6'd9: knot = 8'h6d;
         6'd10: knot = 8'h78;
         6'd11: knot = 8'h83;
         6'd12: knot = 8'h8e;
         6'd13: knot = 8'h98;
         6'd14: knot = 8'ha2;
         6'd15: knot = 8'hab;
         6'd16: knot = 8'hb4;
         6'd17: knot = 8'hbd;
         6'd18: knot = 8'hc5;
         6'd19: knot = 8'hcd;
         6'd20: knot = 8'hd4;
         6'd21: knot = 8'hdb;
         6'd22: knot = 8'he1;
         6'd23: knot = 8'he7;
         6'd24: knot = 8'hec;
         6'd25: knot = 8'hf0;
         6'd26: knot = 8'hf4;
         6'd27: knot = 8'hf7;
         6'd28: knot = 8'hfa;
         6'd29: knot = 8'hfc;
         6'd30: knot = 8'hfe;
         default: knot = 8'hff;
      endcase
   endfunction

   // magnitude of the first quadrant, x in 0..256
   function automatic logic [7:0] quarter(input logic [8:0] x);
      logic [7:0] a;
      logic [7:0] b;
      logic [10:0] d;
      a = knot(x[8:3]);
      b = knot(6'(x[8:3] + 6'd1));
      d = 11'(b - a) * 11'(x[2:0]);
      quarter = 8'(a + 8'(d >> 3));
   endfunction

   // full wave from quadrant and offset
   function automatic ssq_pkg::ssq_cur_t wave(input ssq_pkg::ssq_pos_t p);
      logic [7:0] m;
      m = p[8] ? quarter(9'h100 - 9'(p[7:0])) : quarter(9'(p[7:0]));
      wave = p[9] ? -$signed({1'b0, m}) : $signed({1'b0, m});
   endfunction

   assign sin_val = wave(pos);
   assign cos_val = wave(10'(pos + 10'h100));

endmodule // ssq_sine_lut

`default_nettype wire

/* File: hw/ssq_top.sv */
// step/direction microstep sequencer with interpolation and AXI4-Lite registers
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ssq_defs.svh"

// Notes on behaviour
// - only rising step edges advance the sequence
// - step and direction synchronised before use
// - 1024-entry sine table indexed by position (here a 33-knot quarter table, interpolated)
// - direction low adds width, high subtracts
// - step width doubles per coarser resolution
// - coarser resolution snaps to nearest valid position
// - valid positions are odd multiples of half-width (only a coarser snap enforces this; reset position 0 is not one)
// - interpolate each step over previous interval
// - microsteps per input step equal width
// - microstep spacing capped; longer means standstill
// - standstill starts standby if power-down selected
// - standstill flag set, cleared by next step
// - faster rate adopted; leftover microsteps skipped
// - index active at coil A zero point
// - position counter wraps modulo 1024
// - index toggles per step when configured
module ssq_top #(
   parameter int STST_LIMIT = `SSQ_STST_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic STEP,
   input wire logic DIR,
   input wire logic POWER_DOWN_SELECT_PIN,
   output logic INDEX,
   output logic STANDBY,
   output ssq_pkg::ssq_cur_t COIL_A,
   output ssq_pkg::ssq_cur_t COIL_B,
   output logic IRQ,
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic step_s1_q, step_s2_q, step_s3_q;
   logic dir_s1_q, dir_s2_q;
   logic step_edge;
   ssq_pkg::ssq_res_t res_q, res_prev_q, res_eff;
   logic idx_tgl_q;
   logic [1:0] int_stat_q, int_mask_q, int_set;
   ssq_pkg::ssq_pos_t pos_q, target, snapped;
   logic [8:0] rem_q, width;
   logic [9:0] width10;
   logic dir_q;
   logic [20:0] per_q, last_per_q, ivc_q, interval;
   logic tick, coarser;
   logic stst_q, stst_set;
   logic index_q, tgl_q;
   logic zero_prev_q;
   ssq_pkg::ssq_cur_t sin_w, cos_w, coil_a_q, coil_b_q;
   logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   ssq_pkg::ssq_resp_t bresp_q, rresp_q;
   logic wr_fire;
   logic [31:0] rd_mux;
   logic rd_hit;

   // -------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         step_s1_q <= 1'b0;
         step_s2_q <= 1'b0;
         step_s3_q <= 1'b0;
         dir_s1_q <= 1'b0;
         dir_s2_q <= 1'b0;
      end else if (CE) begin
         step_s1_q <= STEP;
         step_s2_q <= step_s1_q;
         step_s3_q <= step_s2_q;
         dir_s1_q <= DIR;
         dir_s2_q <= dir_s1_q;
      end
   end

   // falling edges are deliberately ignored
   assign step_edge = CE & step_s2_q & ~step_s3_q;

   // -------------------------------------------------------------
   // resolution, width and snapping
   // -------------------------------------------------------------
   // codes above fullstep are treated as fullstep
   assign res_eff = (res_q > `SSQ_RES_FULL) ? `SSQ_RES_FULL : res_q;
   assign width = 9'h001 << res_eff;
   assign width10 = 10'h001 << res_eff;
   assign coarser = res_eff > res_prev_q;
   // odd multiple of half width nearest to the pending target
   assign snapped = (target & ~10'(width10 - 10'h001)) | (width10 >> 1);
   // position the interpolator is heading for
   assign target = dir_q ? 10'(pos_q - 10'(rem_q)) : 10'(pos_q + 10'(rem_q));

   // -------------------------------------------------------------
   // step period measurement and standstill
   // -------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         per_q <= 21'h000000;
         last_per_q <= 21'h000000;
      end else if (CE) begin
         if (step_edge) begin
            per_q <= 21'h000000;
            last_per_q <= per_q;
         end else if (per_q < 21'(STST_LIMIT)) begin
            per_q <= 21'(per_q + 21'h000001);
         end
      end
   end

   // a period too long to spread is a standstill
   assign stst_set = CE & ~step_edge & ~stst_q & (per_q == 21'(STST_LIMIT - 1));

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         stst_q <= 1'b0;
      end else if (CE) begin
         if (step_edge) begin
            stst_q <= 1'b0;
         end else if (stst_set) begin
            stst_q <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // microstep interpolator
   // -------------------------------------------------------------
   // spacing is period / width; width is a power of two so a shift does it
   always_comb begin
      interval = last_per_q >> res_eff;
      if (interval > 21'(STST_LIMIT)) begin
         interval = 21'(STST_LIMIT);
      end
      if (interval == 21'h000000) begin
         interval = 21'h000001;
      end
   end

   assign tick = (rem_q != 9'h000) && (21'(ivc_q + 21'h000001) >= interval);

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pos_q <= `SSQ_POS_RST;
         rem_q <= 9'h000;
         dir_q <= 1'b0;
         ivc_q <= 21'h000000;
         res_prev_q <= `SSQ_CTRL_RES_RST;
      end else if (CE) begin
         res_prev_q <= res_eff;
         if (step_edge) begin
            // unfinished microsteps are dropped: jump to the old target
            pos_q <= coarser ? snapped : target;
            rem_q <= width;
            dir_q <= dir_s2_q;
            ivc_q <= 21'h000000;
         end else if (coarser) begin
            pos_q <= snapped;
            rem_q <= 9'h000;
            ivc_q <= 21'h000000;
         end else if (tick) begin
            // 10-bit arithmetic wraps 1023 <-> 0
            pos_q <= dir_q ? 10'(pos_q - 10'h001) : 10'(pos_q + 10'h001);
            rem_q <= 9'(rem_q - 9'h001);
            ivc_q <= 21'h000000;
         end else if (rem_q != 9'h000) begin
            ivc_q <= 21'(ivc_q + 21'h000001);
         end
      end
   end

   // -------------------------------------------------------------
   // coil currents
   // -------------------------------------------------------------
   ssq_sine_lut u_lut (
      .pos(pos_q),
      .sin_val(sin_w),
      .cos_val(cos_w)
   );

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         coil_a_q <= 9'sh000;
         coil_b_q <= 9'sh000;
      end else if (CE) begin
         coil_a_q <= sin_w;
         coil_b_q <= cos_w;
      end
   end

   // -------------------------------------------------------------
   // index output
   // -------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tgl_q <= 1'b0;
         index_q <= 1'b0;
         // position resets to 0: no false zero event after reset
         zero_prev_q <= 1'b1;
      end else if (CE) begin
         if (step_edge) begin
            tgl_q <= ~tgl_q;
         end
         zero_prev_q <= (pos_q == 10'h000);
         index_q <= idx_tgl_q ? tgl_q : (pos_q == 10'h000);
      end
   end

   // -------------------------------------------------------------
   // interrupts: set wins over a same-cycle clear
   // -------------------------------------------------------------
   assign int_set[`SSQ_INT_STST_BIT] = stst_set;
   assign int_set[`SSQ_INT_INDEX_BIT] = CE & (pos_q == 10'h000) & ~zero_prev_q;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         int_stat_q <= 2'h0;
      end else if (CE) begin
         if (wr_fire && awaddr_q == `SSQ_ADDR_INT_STATUS && wdata_q[1:0] != 2'h0) begin
            int_stat_q <= (int_stat_q & ~wdata_q[1:0]) | int_set;
         end else begin
            int_stat_q <= int_stat_q | int_set;
         end
      end
   end

   // -------------------------------------------------------------
   // AXI4-Lite write channel
   // -------------------------------------------------------------
   assign S_AXI_AWREADY = CE & ~aw_have_q & ~bvalid_q;
   assign S_AXI_WREADY = CE & ~w_have_q & ~bvalid_q;
   assign wr_fire = CE & aw_have_q & w_have_q & ~bvalid_q;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h00000000;
         bvalid_q <= 1'b0;
         bresp_q <= `SSQ_RESP_OKAY;
      end else if (CE) begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_q <= 1'b1;
            awaddr_q <= {S_AXI_AWADDR[3:2], 2'b00};
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_q <= 1'b1;
            // only the low byte lane holds writable bits
            wdata_q <= S_AXI_WSTRB[0] ? S_AXI_WDATA : 32'h00000000;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q == `SSQ_ADDR_STATUS) ? `SSQ_RESP_SLVERR : `SSQ_RESP_OKAY;
         end else if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         res_q <= `SSQ_CTRL_RES_RST;
         idx_tgl_q <= `SSQ_CTRL_IDX_TGL_RST;
         int_mask_q <= `SSQ_INT_MASK_RST;
      end else if (CE && wr_fire) begin
         if (awaddr_q == `SSQ_ADDR_CTRL) begin
            // resolution may change at any time, snapping follows a change to a coarser one
            res_q <= wdata_q[`SSQ_CTRL_RES_MSB:`SSQ_CTRL_RES_LSB];
            idx_tgl_q <= wdata_q[`SSQ_CTRL_IDX_TGL_BIT];
         end else if (awaddr_q == `SSQ_ADDR_INT_MASK) begin
            int_mask_q <= wdata_q[1:0];
         end
      end
   end

   // -------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case ({S_AXI_ARADDR[3:2], 2'b00})
         `SSQ_ADDR_CTRL: begin
            rd_mux[`SSQ_CTRL_RES_MSB:`SSQ_CTRL_RES_LSB] = res_q;
            rd_mux[`SSQ_CTRL_IDX_TGL_BIT] = idx_tgl_q;
         end
         `SSQ_ADDR_STATUS: begin
            rd_mux[`SSQ_STAT_POS_MSB:`SSQ_STAT_POS_LSB] = pos_q;
            rd_mux[`SSQ_STAT_STST_BIT] = stst_q;
            rd_mux[`SSQ_STAT_STBY_BIT] = STANDBY;
         end
         `SSQ_ADDR_INT_STATUS: rd_mux[1:0] = int_stat_q;
         `SSQ_ADDR_INT_MASK: rd_mux[1:0] = int_mask_q;
         default: rd_hit = 1'b0;
      endcase
   end

   assign S_AXI_ARREADY = CE & ~rvalid_q;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `SSQ_RESP_OKAY;
      end else if (CE) begin
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? `SSQ_RESP_OKAY : `SSQ_RESP_SLVERR;
         end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign STANDBY = stst_q & POWER_DOWN_SELECT_PIN;
   assign INDEX = index_q;
   assign COIL_A = coil_a_q;
   assign COIL_B = coil_b_q;
   assign IRQ = |(int_stat_q & int_mask_q);
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

endmodule // ssq_top

`default_nettype wire

/* File: testbench/ssq_step_source.sv */
// step/direction source standing in for the motion controller
`timescale 1ns/1ps
`default_nettype none
module ssq_step_source (
   input wire logic clk,
   output logic step,
   output logic dir
);
   initial begin
      step = 1'b0;
      dir = 1'b0;
   end
   // direction flips once its hold is over, so a late sample shows up
   task automatic pulse(input logic d);
      begin
         @(posedge clk);
         dir <= d;
         @(posedge clk);
         step <= 1'b1;
         repeat (2) @(posedge clk);
         dir <= !d;
         @(posedge clk);
         step <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule // ssq_step_source
`default_nettype wire

/* File: testbench/ssq_top_bench.sv */
// self-checking bench of the step/direction microstep sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssq_defs.svh"
module ssq_top_bench;
   localparam int STST = 64;
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b0, pdsel = 1'b0, idx, stby, irq, step, dir, b;
   logic [3:0] awaddr = 4'h0, wstrb = 4'hf, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   ssq_pkg::ssq_cur_t coil_a, coil_b;
   int n_mismatch = 0, check_count = 0, pos = 0, w = 16, res = 4;

   always #12.5 clk = ~clk;
   ssq_step_source ssq_step_source_i (.clk(clk), .step(step), .dir(dir));
   ssq_top #(.STST_LIMIT(STST)) ssq_top_i (
      .CLK(clk), .RST_N(rst_n), .CE(ce), .STEP(step), .DIR(dir),
      .POWER_DOWN_SELECT_PIN(pdsel), .INDEX(idx), .STANDBY(stby),
      .COIL_A(coil_a), .COIL_B(coil_b), .IRQ(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic summarize;
      begin
         if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      begin
         check_count++;
         if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   // readies sampled on the falling edge equal their value at the next rising edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [1:0] rs);
      logic pa, pw, dn;
      begin
         @(posedge clk);
         pa = 1'b1;
         pw = 1'b1;
         dn = 1'b0;
         awaddr <= a;
         wdata <= d;
         wstrb <= s;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         while (!dn) begin
            @(negedge clk);
            dn = bvalid && bready;
            rs = bresp;
            pa = pa && !awready;
            pw = pw && !wready;
            @(posedge clk);
            if (!pa) awvalid <= 1'b0;
            if (!pw) wvalid <= 1'b0;
            if (!pa && !pw && !dn && $urandom % 2) bready <= 1'b1;
         end
         bready <= 1'b0;
      end
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      logic pa, dn;
      logic [1:0] rr;
      begin
         @(posedge clk);
         pa = 1'b1;
         dn = 1'b0;
         araddr <= a;
         arvalid <= 1'b1;
         while (!dn) begin
            @(negedge clk);
            dn = rvalid && rready;
            d = rdata;
            rr = rresp;
            pa = pa && !arready;
            @(posedge clk);
            if (!pa) arvalid <= 1'b0;
            if (!pa && !dn && $urandom % 2) rready <= 1'b1;
         end
         rready <= 1'b0;
         chk(rr, `SSQ_RESP_OKAY);
      end
   endtask
   // one pulse moves one width, its falling edge nothing
   task automatic stp(input logic d, input int n);
      begin
         ssq_step_source_i.pulse(d);
         pos = (pos + (d ? 1024 - w : w)) % 1024;
         repeat (n) @(posedge clk);
      end
   endtask
   task automatic chkpos;
      begin
         rd(`SSQ_ADDR_STATUS, v);
         chk(v[9:0], pos);
      end
   endtask
   task automatic setres(input int nr, input logic tgl);
      begin
         wr(`SSQ_ADDR_CTRL, {tgl, nr[3:0]}, 4'hf, r);
         chk(r, `SSQ_RESP_OKAY);
         if (nr > 8) nr = 8;
         if (nr > res) pos = (pos & ~((1 << nr) - 1)) | ((1 << nr) / 2);
         res = nr;
         w = 1 << nr;
      end
   endtask

   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(30));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      rd(`SSQ_ADDR_CTRL, v);
      chk(v, `SSQ_CTRL_RES_RST);
      rd(`SSQ_ADDR_INT_MASK, v);
      chk(v, `SSQ_INT_MASK_RST);
      chkpos;
      rd(`SSQ_ADDR_INT_STATUS, v);
      chk(v[1], 0);
      @(negedge clk);
      chk(coil_a, 0);
      chk(coil_b, 255);
      chk(idx, 1);
      stp(1'b1, 600);
      chkpos;
      for (int i = 0; i < 4; i++) begin
         stp($urandom % 2, 600);
         chkpos;
      end
      for (int i = 0; i < 9; i++) begin
         setres(i, 1'b0);
         rd(`SSQ_ADDR_CTRL, v);
         chk(v, i);
         repeat (2) begin
            stp($urandom % 2, 600);
            chkpos;
         end
      end
      @(negedge clk);
      chk(coil_a * coil_a, coil_b * coil_b);
      setres(9, 1'b0);
      stp($urandom % 2, 600);
      chkpos;
      wr(`SSQ_ADDR_STATUS, 32'h3ff, 4'hf, r);
      chk(r, `SSQ_RESP_SLVERR);
      chkpos;
      // byte 0 strobe low writes zeros, which is resolution 0
      wr(`SSQ_ADDR_CTRL, 32'h5, 4'he, r);
      rd(`SSQ_ADDR_CTRL, v);
      chk(v, 0);
      res = 0;
      w = 1;
      // second step lands before the first one's slow microstep
      stp(1'b0, 0);
      stp(1'b0, 600);
      chkpos;
      wr(`SSQ_ADDR_INT_STATUS, 32'h3, 4'hf, r);
      wr(`SSQ_ADDR_INT_MASK, 32'h1, 4'hf, r);
      rd(`SSQ_ADDR_STATUS, v);
      chk(v[17:16], 2'h1);
      @(negedge clk);
      chk(irq, 0);
      @(posedge clk);
      pdsel <= 1'b1;
      repeat (2) @(negedge clk);
      chk(stby, 1);
      stp(1'b0, 0);
      rd(`SSQ_ADDR_STATUS, v);
      chk(v[16], 0);
      repeat (200) @(posedge clk);
      @(negedge clk);
      chk(irq, 1);
      chk(stby, 1);
      wr(`SSQ_ADDR_INT_STATUS, 32'h1, 4'hf, r);
      @(negedge clk);
      chk(irq, 0);
      wr(`SSQ_ADDR_INT_MASK, 32'h0, 4'hf, r);
      // clock enable low must hold the pending microstep back
      stp(1'b1, 0);
      ce <= 1'b0;
      repeat (100) @(posedge clk);
      ce <= 1'b1;
      rd(`SSQ_ADDR_STATUS, v);
      chk(v[9:0], (pos + 1) % 1024);
      repeat (100) @(posedge clk);
      rd(`SSQ_ADDR_INT_STATUS, v);
      chk(v[0], 1);
      @(negedge clk);
      chk(irq, 0);
      chkpos;
      setres(0, 1'b1);
      for (int i = 0; i < 2; i++) begin
         @(negedge clk);
         b = idx;
         stp($urandom % 2, 100);
         @(negedge clk);
         chk(idx, !b);
      end
      chkpos;
      summarize;
   end

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      summarize;
   end
endmodule // ssq_top_bench
`default_nettype wire

/* File: testbench/ssq_top_properties.sv */
// port-level checks of the step/direction microstep sequencer
`timescale 1ns/1ps
`default_nettype none
module ssq_top_properties #(
   parameter int STST_LIMIT = 1048576
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic STEP,
   input wire logic POWER_DOWN_SELECT_PIN,
   input wire logic STANDBY,
   input wire ssq_pkg::ssq_cur_t COIL_A,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   property p_standby;
      STANDBY |-> POWER_DOWN_SELECT_PIN;
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby without select pin");
   property p_stst_clear;
      $rose(STEP) |-> ##[3:4] !STANDBY;
   endproperty
   a_stst_clear: assert property (p_stst_clear)
      else $error("standstill not cleared by step");
   // the synchroniser delay must keep coil A still for two cycles
   property p_sync;
      $rose(STEP) && STANDBY |=> $stable(COIL_A) [*2];
   endproperty
   a_sync: assert property (p_sync)
      else $error("step acted before synchronisation");
   property p_b_after;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
   endproperty
   a_b_after: assert property (p_b_after)
      else $error("write response late");
   property p_r_after;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
   endproperty
   a_r_after: assert property (p_r_after)
      else $error("read response late");
   property p_b_hold;
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   property p_r_hold;
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   property p_aw_refuse;
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
   endproperty
   a_aw_refuse: assert property (p_aw_refuse)
      else $error("write taken while response pending");
   property p_ce;
      !CE |-> !(S_AXI_AWREADY || S_AXI_WREADY || S_AXI_ARREADY);
   endproperty
   a_ce: assert property (p_ce)
      else $error("ready while clock enable low");
   c_step_stst: cover property ($rose(STEP) && STANDBY);
   c_write: cover property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID);
   c_b_wait: cover property (S_AXI_BVALID && !S_AXI_BREADY);
   c_ce_low: cover property (!CE);
endmodule // ssq_top_properties

bind ssq_top ssq_top_properties #(.STST_LIMIT(STST_LIMIT)) ssq_top_properties_i (.*);
`default_nettype wire
